// [rtl/wkdet_pkg.sv]
// constants and types for the wake input detection block
package wkdet_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned SHORT_FILTER_US = 16;
  localparam int unsigned LONG_FILTER_US = 64;
  localparam int unsigned SHORT_FILTER_CYC = SHORT_FILTER_US * CLK_MHZ;
  localparam int unsigned LONG_FILTER_CYC = LONG_FILTER_US * CLK_MHZ;
  localparam int unsigned CNT_W = 14;
  localparam int unsigned NUM_PINS = 3;
  localparam int unsigned NUM_ALT = 2;
  localparam int unsigned NUM_CH = NUM_PINS + NUM_ALT;
  localparam logic [3:0] ADDR_ENABLE = 4'h0;
  localparam logic [3:0] ADDR_FILTER = 4'h1;
  localparam logic [3:0] ADDR_BIAS = 4'h2;
  localparam logic [3:0] ADDR_SRC_STATUS = 4'h3;
  localparam logic [3:0] ADDR_ALT_STATUS = 4'h4;
  localparam logic [3:0] ADDR_LEVEL = 4'h5;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
  localparam logic [3:0] ADDR_ALT_CFG = 4'h7;
  localparam logic [2:0] ENABLE_RST = 3'h0;
  localparam logic [5:0] FILTER_RST = 6'h00;
  localparam logic [5:0] BIAS_RST = 6'h00;
  localparam logic [4:0] MASK_RST = 5'h00;
  localparam logic [1:0] ALT_CFG_RST = 2'h0;
  localparam int unsigned FILT_POS_PIN2 = 2;
  localparam int unsigned FILT_POS_PIN3 = 4;
  localparam logic [7:0] READ_ZERO = 8'h00;
  typedef enum logic [1:0] {
    WKDET_FLT_STATIC_SHORT = 2'b00,
    WKDET_FLT_STATIC_LONG = 2'b01,
    WKDET_FLT_CYCLIC_A = 2'b10,
    WKDET_FLT_CYCLIC_B = 2'b11
  } wkdet_filter_t;
  typedef enum logic [1:0] {
    WKDET_BIAS_NONE = 2'b00,
    WKDET_BIAS_DOWN = 2'b01,
    WKDET_BIAS_UP = 2'b10,
    WKDET_BIAS_AUTO = 2'b11
  } wkdet_bias_t;
  typedef enum logic [1:0] {
    WKDET_MODE_NORMAL = 2'b00,
    WKDET_MODE_STOP = 2'b01,
    WKDET_MODE_SLEEP = 2'b10,
    WKDET_MODE_FAILSAFE = 2'b11
  } wkdet_mode_t;
endpackage

// [rtl/wkdet_filter_if.sv]
// interface between the top and one filter channel
`timescale 1ns/1ps
`default_nettype none
interface wkdet_filter_if;
  logic level_in;
  logic sample_en;
  logic long_sel;
  logic event_pulse;
  logic level_out;
  modport ctrl (output level_in, output sample_en, output long_sel, input event_pulse, input level_out);
  modport chan (input level_in, input sample_en, input long_sel, output event_pulse, output level_out);
endinterface
`default_nettype wire

// [rtl/wkdet_filter.sv]
// glitch filter and edge detector for one wake input
`timescale 1ns/1ps
`default_nettype none
module wkdet_filter (
  input wire logic ref_clk,
  input wire logic rst_n,
  wkdet_filter_if.chan fif
);
  typedef struct packed {
    logic stable;
    logic cand;
    logic busy;
    logic [wkdet_pkg::CNT_W-1:0] cnt;
    logic evt;
  } wkdet_fstate_t;
  wkdet_fstate_t s;
  wkdet_fstate_t next_s;
  logic [wkdet_pkg::CNT_W-1:0] limit;
  always_comb begin
    limit = fif.long_sel ? wkdet_pkg::CNT_W'(wkdet_pkg::LONG_FILTER_CYC - 1)
                         : wkdet_pkg::CNT_W'(wkdet_pkg::SHORT_FILTER_CYC - 1);
    next_s = s;
    next_s.evt = 1'b0;
    if (!fif.sample_en) begin
      next_s.busy = 1'b0;
    end else if (!s.busy) begin
      if (fif.level_in != s.stable) begin
        next_s.busy = 1'b1;
        next_s.cand = fif.level_in;
        next_s.cnt = '0;
      end
    end else if (fif.level_in != s.cand) begin
      next_s.busy = 1'b0;
    end else if (s.cnt >= limit) begin
      next_s.busy = 1'b0;
      next_s.stable = s.cand;
      next_s.evt = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 1'b1;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign fif.event_pulse = s.evt;
  assign fif.level_out = s.stable;
endmodule
`default_nettype wire

// [rtl/wkdet_top.sv]
// wake input detection: sync, filters, flags, levels, bias and registers
//
// Operation
// - both edges of a wake pin raise events
// - interrupt in normal/stop, wake in sleep/failsafe
// - static or cyclic sense chosen by software
// - static sense watches inputs continuously
// - cyclic sense evaluates only inside active window
// - static filter selectable 16us or 64us
// - event only if level holds whole filter
// - per-pin wake enable in control register
// - per-pin wake source flags, always readable
// - level register shows pin levels in normal/stop, reads zero in sleep/failsafe
// - cyclic sense level is last window sample
// - alternate pins 16us filter, second status
// - software selects pull-up or pull-down per pin
// - cyclic sense paced by timer a or b
// - filter field decode 00/01/10/11
// - bias field decode incl automatic switching
`timescale 1ns/1ps
`default_nettype none
module wkdet_top #(
  parameter int unsigned NUM_PINS = wkdet_pkg::NUM_PINS,
  parameter int unsigned NUM_ALT = wkdet_pkg::NUM_ALT
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [2:0] wake_input_pin,
  input wire logic [1:0] failure_output_pins,
  input wire logic cyclic_timer_a,
  input wire logic cyclic_timer_b,
  input wire logic [1:0] power_mode,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic irq,
  output logic wake_request,
  output logic [2:0] pull_up_en,
  output logic [2:0] pull_down_en
);
  localparam int unsigned NCH = NUM_PINS + NUM_ALT;
  typedef struct packed {
    logic [NCH-1:0] sync1;
    logic [NCH-1:0] sync2;
    logic [1:0] tmr_a_sync;
    logic [1:0] tmr_b_sync;
    logic [2:0] wake_enable_control;
    logic [5:0] filter_cfg;
    logic [5:0] bias_cfg;
    logic [1:0] alt_cfg;
    logic [2:0] wake_source_status;
    logic [1:0] alt_wake_status;
    logic [2:0] pin_level_status;
    logic [4:0] irq_mask;
    logic [7:0] rdata;
    logic irq;
    logic wake;
    logic [2:0] pu;
    logic [2:0] pd;
  } wkdet_state_t;
  wkdet_state_t s;
  wkdet_state_t next_s;
  logic [NCH-1:0] ch_event;
  logic [NCH-1:0] ch_level;
  logic [NCH-1:0] ch_win;
  logic [NCH-1:0] ch_cyclic;
  logic [NCH-1:0] ch_long;
  logic [NCH-1:0] raw_in;
  logic [NUM_PINS-1:0] pin_evt;
  logic [NUM_ALT-1:0] alt_evt;
  logic active_mode;
  logic [4:0] status_all;
  logic [7:0] rd_mux;
  logic [2:0] src_clr;
  logic [1:0] alt_clr;
  assign raw_in = {failure_output_pins, wake_input_pin};
  assign active_mode = (power_mode == wkdet_pkg::WKDET_MODE_NORMAL) ||
                       (power_mode == wkdet_pkg::WKDET_MODE_STOP);
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      wkdet_filter_if fif();
      if (gi < NUM_PINS) begin : g_pin
        wkdet_pkg::wkdet_filter_t fsel;
        assign fsel = wkdet_pkg::wkdet_filter_t'(s.filter_cfg[2*gi +: 2]);
        assign ch_cyclic[gi] = fsel[1];
        assign ch_long[gi] = (fsel == wkdet_pkg::WKDET_FLT_STATIC_LONG);
        assign ch_win[gi] = !fsel[1] ? 1'b1 :
                            (fsel[0] ? s.tmr_b_sync[1] : s.tmr_a_sync[1]);
        assign pin_evt[gi] = fif.event_pulse && s.wake_enable_control[gi];
      end else begin : g_alt
        assign ch_cyclic[gi] = 1'b0;
        assign ch_long[gi] = 1'b0;
        assign ch_win[gi] = s.alt_cfg[gi-NUM_PINS];
        assign alt_evt[gi-NUM_PINS] = fif.event_pulse;
      end
      assign fif.level_in = s.sync2[gi];
      assign fif.sample_en = ch_win[gi];
      assign fif.long_sel = ch_long[gi];
      assign ch_event[gi] = fif.event_pulse;
      assign ch_level[gi] = fif.level_out;
      wkdet_filter u_filter (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .fif(fif.chan)
      );
    end
  endgenerate
  always_comb begin
    src_clr = '0;
    alt_clr = '0;
    if (reg_write && reg_addr == wkdet_pkg::ADDR_SRC_STATUS) begin
      src_clr = reg_wdata[2:0];
    end
    if (reg_write && reg_addr == wkdet_pkg::ADDR_ALT_STATUS) begin
      alt_clr = reg_wdata[1:0];
    end
  end
  assign status_all = {s.alt_wake_status, s.wake_source_status};
  always_comb begin
    if (reg_addr == wkdet_pkg::ADDR_ENABLE) begin
      rd_mux = {5'h00, s.wake_enable_control};
    end else if (reg_addr == wkdet_pkg::ADDR_FILTER) begin
      rd_mux = {2'h0, s.filter_cfg};
    end else if (reg_addr == wkdet_pkg::ADDR_BIAS) begin
      rd_mux = {2'h0, s.bias_cfg};
    end else if (reg_addr == wkdet_pkg::ADDR_SRC_STATUS) begin
      rd_mux = {5'h00, s.wake_source_status};
    end else if (reg_addr == wkdet_pkg::ADDR_ALT_STATUS) begin
      rd_mux = {6'h00, s.alt_wake_status};
    end else if (reg_addr == wkdet_pkg::ADDR_LEVEL) begin
      rd_mux = active_mode ? {5'h00, s.pin_level_status} : wkdet_pkg::READ_ZERO;
    end else if (reg_addr == wkdet_pkg::ADDR_IRQ_MASK) begin
      rd_mux = {3'h0, s.irq_mask};
    end else if (reg_addr == wkdet_pkg::ADDR_ALT_CFG) begin
      rd_mux = {6'h00, s.alt_cfg};
    end else begin
      rd_mux = wkdet_pkg::READ_ZERO;
    end
  end
  always_comb begin
    next_s = s;
    next_s.sync1 = raw_in;
    next_s.sync2 = s.sync1;
    next_s.tmr_a_sync = {s.tmr_a_sync[0], cyclic_timer_a};
    next_s.tmr_b_sync = {s.tmr_b_sync[0], cyclic_timer_b};
    if (reg_write) begin
      if (reg_addr == wkdet_pkg::ADDR_ENABLE) begin
        next_s.wake_enable_control = reg_wdata[2:0];
      end else if (reg_addr == wkdet_pkg::ADDR_FILTER) begin
        next_s.filter_cfg = reg_wdata[5:0];
      end else if (reg_addr == wkdet_pkg::ADDR_BIAS) begin
        next_s.bias_cfg = reg_wdata[5:0];
      end else if (reg_addr == wkdet_pkg::ADDR_IRQ_MASK) begin
        next_s.irq_mask = reg_wdata[4:0];
      end else if (reg_addr == wkdet_pkg::ADDR_ALT_CFG) begin
        next_s.alt_cfg = reg_wdata[1:0];
      end
    end
    // set wins over write-one clear
    next_s.wake_source_status = (s.wake_source_status & ~src_clr) | pin_evt;
    next_s.alt_wake_status = (s.alt_wake_status & ~alt_clr) | alt_evt;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (!ch_cyclic[i]) begin
        next_s.pin_level_status[i] = s.sync2[i];
      end else if (ch_win[i]) begin
        next_s.pin_level_status[i] = s.sync2[i];
      end
    end
    for (int i = 0; i < NUM_PINS; i++) begin
      case (wkdet_pkg::wkdet_bias_t'(s.bias_cfg[2*i +: 2]))
        wkdet_pkg::WKDET_BIAS_NONE: begin
          next_s.pu[i] = 1'b0;
          next_s.pd[i] = 1'b0;
        end
        wkdet_pkg::WKDET_BIAS_DOWN: begin
          next_s.pu[i] = 1'b0;
          next_s.pd[i] = 1'b1;
        end
        wkdet_pkg::WKDET_BIAS_UP: begin
          next_s.pu[i] = 1'b1;
          next_s.pd[i] = 1'b0;
        end
        default: begin
          next_s.pu[i] = s.sync2[i];
          next_s.pd[i] = !s.sync2[i];
        end
      endcase
    end
    next_s.irq = active_mode && |(status_all & s.irq_mask);
    next_s.wake = !active_mode && |pin_evt;
    next_s.rdata = reg_read ? rd_mux : wkdet_pkg::READ_ZERO;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.wake_enable_control <= wkdet_pkg::ENABLE_RST;
      s.filter_cfg <= wkdet_pkg::FILTER_RST;
      s.bias_cfg <= wkdet_pkg::BIAS_RST;
      s.irq_mask <= wkdet_pkg::MASK_RST;
      s.alt_cfg <= wkdet_pkg::ALT_CFG_RST;
    end else begin
      s <= next_s;
    end
  end
  assign reg_rdata = s.rdata;
  assign irq = s.irq;
  assign wake_request = s.wake;
  assign pull_up_en = s.pu;
  assign pull_down_en = s.pd;
endmodule
`default_nettype wire

// [tb/wkdet_top_assertions.sv]
// port-level assertions for the wake input detection block
`timescale 1ns/1ps
`default_nettype none
module wkdet_top_assertions #(
  parameter int unsigned NUM_PINS = 3,
  parameter int unsigned NUM_ALT = 2
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [2:0] wake_input_pin,
  input wire logic [1:0] failure_output_pins,
  input wire logic cyclic_timer_a,
  input wire logic cyclic_timer_b,
  input wire logic [1:0] power_mode,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic irq,
  input wire logic wake_request,
  input wire logic [2:0] pull_up_en,
  input wire logic [2:0] pull_down_en
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] en, pin_q;
  logic [5:0] bias;
  logic [13:0] cnt;
  // shadows of enable and bias, age of the pin levels
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      en <= 3'h0;
      bias <= 6'h00;
      pin_q <= 3'h0;
      cnt <= 14'h0000;
    end else begin
      pin_q <= wake_input_pin;
      if (reg_write && reg_addr == wkdet_pkg::ADDR_ENABLE) begin
        en <= reg_wdata[2:0];
      end
      if (reg_write && reg_addr == wkdet_pkg::ADDR_BIAS) begin
        bias <= reg_wdata[5:0];
      end
      if (pin_q != wake_input_pin) begin
        cnt <= 14'h0000;
      end else if (cnt != 14'h3FFF) begin
        cnt <= cnt + 14'h0001;
      end
    end
  end
  sequence s_wake;
    wake_request;
  endsequence
  sequence s_lvl_rd;
    reg_read && reg_addr == wkdet_pkg::ADDR_LEVEL && power_mode[1] ##1 1'b1;
  endsequence
  property p_bias_excl; (pull_up_en & pull_down_en) == 3'h0; endproperty
  property p_bias_fix; bias[1:0] != 2'h3 && $stable(bias[1:0]) |-> {pull_up_en[0], pull_down_en[0]} == bias[1:0];
  endproperty
  property p_wake_mode; s_wake |-> $past(power_mode[1]); endproperty
  property p_wake_pulse; s_wake |=> !wake_request; endproperty
  property p_wake_en; s_wake |-> en != 3'h0; endproperty
  property p_wake_filt; s_wake |-> cnt >= 14'(wkdet_pkg::SHORT_FILTER_CYC - 4); endproperty
  property p_irq_mode; irq |-> !$past(power_mode[1]); endproperty
  property p_lvl_sleep; s_lvl_rd |-> reg_rdata == wkdet_pkg::READ_ZERO; endproperty
  a_bias_excl: assert property (p_bias_excl) else $error("pull up and down on together");
  a_bias_fix: assert property (p_bias_fix) else $error("pull enables differ from bias field");
  a_wake_mode: assert property (p_wake_mode) else $error("wake request in active mode");
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake request longer than one cycle");
  a_wake_en: assert property (p_wake_en) else $error("wake request with no pin enabled");
  a_wake_filt: assert property (p_wake_filt) else $error("wake request before filter time");
  a_irq_mode: assert property (p_irq_mode) else $error("irq in low power mode");
  a_lvl_sleep: assert property (p_lvl_sleep) else $error("level read not zero in low power mode");
endmodule
bind wkdet_top wkdet_top_assertions #(.NUM_PINS(NUM_PINS), .NUM_ALT(NUM_ALT)) u_wkdet_top_assertions (
  .ref_clk(ref_clk), .rst_n(rst_n), .wake_input_pin(wake_input_pin),
  .failure_output_pins(failure_output_pins), .cyclic_timer_a(cyclic_timer_a),
  .cyclic_timer_b(cyclic_timer_b), .power_mode(power_mode), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .irq(irq), .wake_request(wake_request), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en)
);
`default_nettype wire

// [tb/wkdet_switch.sv]
// switches driving the wake and alternate pins
`timescale 1ns/1ps
`default_nettype none
module wkdet_switch (
  input wire logic ref_clk,
  input wire logic [4:0] want,
  output logic [4:0] pin
);
  // contacts settle one cycle after the command
  always @(posedge ref_clk) begin
    pin <= want;
  end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the wake input detection block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0, rst_n = 1'b0, cyc_a = 1'b0, cyc_b = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
  logic [1:0] pmode = 2'h0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [4:0] want = 5'h00;
  logic [4:0] pin;
  logic [7:0] rdata;
  logic irq, wake;
  logic [2:0] pu, pd;
  int n_mismatch = 0, n_tests = 0, tick = 0;
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  wkdet_switch u_wkdet_switch (.ref_clk(ref_clk), .want(want), .pin(pin));
  wkdet_top u_wkdet_top (
    .ref_clk(ref_clk), .rst_n(rst_n), .wake_input_pin(pin[2:0]), .failure_output_pins(pin[4:3]),
    .cyclic_timer_a(cyc_a), .cyclic_timer_b(cyc_b), .power_mode(pmode), .reg_addr(addr),
    .reg_wdata(wdata), .reg_write(wr_s), .reg_read(rd_s), .reg_rdata(rdata), .irq(irq),
    .wake_request(wake), .pull_up_en(pu), .pull_down_en(pd)
  );
  function automatic logic [7:0] bexp(input logic [1:0] b, input logic l);
    if (b == 2'h3) return l ? 8'h02 : 8'h01;
    return {6'h00, b};
  endfunction
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_s <= 1'b0;
    #1;
    chk("register", rdata, e);
  endtask
  task automatic flip(input int b);
    @(posedge ref_clk);
    want[b] <= ~want[b];
  endtask
  task automatic mode(input logic [1:0] m);
    @(posedge ref_clk);
    pmode <= m;
  endtask
  // one pin1 edge in mode m: irq when active, wake when asleep
  task automatic hit(input logic [1:0] m);
    logic seen;
    seen = 1'b0;
    mode(m);
    flip(0);
    for (int i = 0; i < 4000; i++) begin
      @(posedge ref_clk);
      #1;
      if (wake === 1'b1) seen = 1'b1;
    end
    chk("wake", {7'h00, seen}, {7'h00, m[1]});
    chk("irq", {7'h00, irq}, {7'h00, ~m[1]});
    rd(4'h3, 8'h01);
    wr(4'h3, 8'h01);
  endtask
  always @(posedge ref_clk) begin
    tick++;
    if (tick == 90000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(68920));
    cyc(5);
    rst_n <= 1'b1;
    for (int a = 0; a < 9; a++) begin
      rd(4'(a), 8'h00);
    end
    $display("reset values done");
    wr(4'h0, 8'h01);
    wr(4'h6, 8'h1F);
    flip(0);
    cyc($urandom_range(100, 3000));
    flip(0);
    cyc(3300);
    rd(4'h3, 8'h00);
    for (int m = 0; m < 4; m++) begin
      hit(2'(m));
    end
    $display("static short filter done");
    mode(2'h0);
    wr(4'h1, 8'h01);
    flip(0);
    cyc($urandom_range(5000, 8000));
    flip(0);
    cyc(200);
    rd(4'h3, 8'h00);
    flip(0);
    cyc(13000);
    rd(4'h3, 8'h01);
    wr(4'h3, 8'h01);
    $display("long filter done");
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h00);
    @(posedge ref_clk);
    want[2:0] <= 3'($urandom);
    cyc(3300);
    rd(4'h3, 8'h00);
    rd(4'h5, {5'h00, want[2:0]});
    mode(2'h2);
    rd(4'h5, 8'h00);
    mode(2'h0);
    $display("enable and level done");
    wr(4'h0, 8'h01);
    wr(4'h1, 8'h02);
    @(posedge ref_clk);
    cyc_a <= 1'b1;
    cyc(3300);
    wr(4'h3, 8'h01);
    cyc_a <= 1'b0;
    cyc(4);
    flip(0);
    cyc(3300);
    rd(4'h3, 8'h00);
    rd(4'h5, {5'h00, want[2:1], ~want[0]});
    cyc_a <= 1'b1;
    cyc(3300);
    wr(4'h3, 8'h01);
    flip(0);
    cyc(3300);
    rd(4'h3, 8'h01);
    wr(4'h3, 8'h01);
    wr(4'h1, 8'h03);
    flip(0);
    cyc(3300);
    rd(4'h3, 8'h00);
    $display("cyclic sense done");
    wr(4'h1, 8'h00);
    wr(4'h7, 8'h03);
    flip(3);
    cyc(3300);
    rd(4'h4, 8'h01);
    chk("irq", {7'h00, irq}, 8'h01);
    wr(4'h4, 8'h01);
    rd(4'h4, 8'h00);
    $display("alternate pins done");
    for (int b = 0; b < 4; b++) begin
      wr(4'h2, {2'h0, 2'(b), 2'(b), 2'(b)});
      cyc(4);
      for (int p = 0; p < 3; p++) begin
        chk("pull", {6'h00, pu[p], pd[p]}, bexp(2'(b), want[p]));
      end
    end
    $display("bias done");
    wrap_up();
  end
endmodule
`default_nettype wire
